// [bridge_cfg_defines.svh]
`ifndef BRIDGE_CFG_DEFINES_SVH
`define BRIDGE_CFG_DEFINES_SVH

// Configuration-space byte offsets
`define OFS_SLOT 8'hc8
`define OFS_LINK0 8'hcc
`define OFS_LINK1 8'hd0
`define OFS_LINK2 8'hd4
`define OFS_PDCAP 8'hd8
`define OFS_PDWORD 8'hdc
`define OFS_WIN0TB 8'he0

// Reset values of whole words
`define RST_SLOT 32'h0000_0000
`define RST_LINK0 32'h0400_1060
`define RST_LINK1 32'h0400_0217
`define RST_LINK2 32'h0019_0254
`define RST_PDWORD 32'h0000_0000
`define RST_WIN0TB 32'h0000_0000

// Writable bit masks of the words with a fixed mask
`define WM_SLOT 32'h0000_07ff
`define WM_LINK0 32'hffff_1fff
`define WM_LINK1 32'hffff_03ff
`define WM_LINK2 32'h007f_7fff
`define WM_PDWORD 32'hffff_ffff

// Fixed header of the product data capability
`define PD_CAP_ID 8'h03
`define PD_NEXT_PTR 8'hf0

// Product data control field positions
`define PD_FLAG_BIT 31
`define PD_ADDR_HI 23
`define PD_ADDR_LO 18

// Product data lives this far into the serial EEPROM
`define PD_EE_OFFSET 9'h040

// Translated base field
`define TB_LO 12

`endif

// [bridge_cfg_pkg.sv]
package bridge_cfg_pkg;

  // Configuration access request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  // Hot-plug slot control outputs
  typedef struct packed {
    logic pwr_ctl;
    logic [1:0] pwr_ind;
    logic [1:0] attn_ind;
    logic [5:0] event_en;
  } slot_ctl_t;

  // Hot-plug slot status inputs
  typedef struct packed {
    logic presence_state;
    logic retention_latch_sensor_state;
    logic [4:0] events;
  } slot_evt_t;

  // Link tuning knobs for the link state machine
  typedef struct packed {
    logic hot_reset_en;
    logic loopback_en;
    logic crosslink_en;
    logic force_config;
    logic debug_sel;
    logic [2:0] lane_retries;
    logic [4:0] ts1_count;
    logic [15:0] l1_entry_timer;
    logic [9:0] l0s_life_timer;
    logic [15:0] l1_life_timer;
    logic [7:0] cdr_fts_count;
    logic [6:0] l0s_exit_lat;
    logic [6:0] l1_exit_lat;
  } link_tuning_t;

  // EEPROM cycle engine states
  typedef enum logic [1:0] {
    EE_IDLE = 2'b00,
    EE_ISSUE = 2'b01,
    EE_WAIT = 2'b11
  } ee_state_t;

endpackage

// [bridge_slot_link_vpd_config.sv]
`timescale 1ns/1ps
`default_nettype none

`include "bridge_cfg_defines.svh"

module bridge_slot_link_vpd_config
  import bridge_cfg_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Configuration access
  input wire logic CFG_REQ,
  input wire cfg_req_t CFG_CMD,
  output logic CFG_ACK,
  output logic [31:0] CFG_RDATA,
  // Hot-plug slot
  input wire slot_evt_t SLOT_EVT,
  output slot_ctl_t SLOT_CTL,
  // Link state machine tuning
  output link_tuning_t LINK_CFG,
  // Upstream memory 0 window
  input wire logic [30:12] WIN0_SIZE,
  input wire logic UP_VALID,
  input wire logic [31:0] UP_ADDR,
  output logic UP_XLAT_VALID,
  output logic [31:0] UP_XLAT_ADDR,
  // Serial EEPROM controller
  output logic EE_REQ,
  output logic EE_WE,
  output logic [8:0] EE_ADDR,
  output logic [31:0] EE_WDATA,
  input wire logic EE_DONE,
  input wire logic [31:0] EE_RDATA
);

  // Byte-enable masked merge of a write into a word
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wdata,
                                           input logic [3:0] be,
                                           input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    return (old & ~m) | (wdata & m);
  endfunction

  // Storage words
  logic [31:0] slot_q; // Slot control half and status half
  logic [31:0] link0_q; // Link tuning word 0
  logic [31:0] link1_q; // Link tuning word 1
  logic [31:0] link2_q; // Link tuning word 2
  logic [5:0] pd_addr_q; // Product data dword address
  logic pd_flag_q; // Product data operation flag
  logic pd_busy_q; // EEPROM cycle in flight
  logic [31:0] pd_word_q; // Product data word
  logic [31:0] win0tb_q; // Translated base word

  // Decoded access strobes
  wire wr_en;
  wire hit_slot;
  wire hit_link0;
  wire hit_link1;
  wire hit_link2;
  wire hit_pdcap;
  wire hit_pdword;
  wire hit_win0tb;
  wire pd_start;
  wire pd_op;
  wire pd_done;
  wire [31:0] pd_rdata;
  wire [31:0] pd_cap_word;
  wire [31:0] win0_wmask;
  wire [31:0] win0_mask;
  wire [31:0] xlat_addr;
  logic [31:0] rd_mux;

  // Write merges and engine address
  wire [31:0] slot_wr; // Slot word with the write applied
  wire [31:0] link0_wr; // Link word 0 with the write applied
  wire [31:0] link1_wr; // Link word 1 with the write applied
  wire [31:0] link2_wr; // Link word 2 with the write applied
  wire [31:0] pd_word_wr; // Product data word with the write applied
  wire [31:0] win0tb_wr; // Translated base with the write applied
  wire [5:0] engine_addr; // Dword address handed to the engine

  assign wr_en = CFG_REQ && CFG_CMD.wr;
  assign hit_slot = CFG_CMD.addr == `OFS_SLOT;
  assign hit_link0 = CFG_CMD.addr == `OFS_LINK0;
  assign hit_link1 = CFG_CMD.addr == `OFS_LINK1;
  assign hit_link2 = CFG_CMD.addr == `OFS_LINK2;
  assign hit_pdcap = CFG_CMD.addr == `OFS_PDCAP;
  assign hit_pdword = CFG_CMD.addr == `OFS_PDWORD;
  assign hit_win0tb = CFG_CMD.addr == `OFS_WIN0TB;

  // A write to the flag byte starts a cycle unless one is running
  assign pd_start = wr_en && hit_pdcap && CFG_CMD.be[3] && !pd_busy_q;
  assign pd_op = CFG_CMD.wdata[`PD_FLAG_BIT];

  // Fixed header plus control fields
  assign pd_cap_word = {pd_flag_q, 7'h00, pd_addr_q, 2'b00, `PD_NEXT_PTR, `PD_CAP_ID};

  // Base bits follow the window size, bit 31 always writable
  assign win0_mask = {1'b1, WIN0_SIZE, 12'h000};
  assign win0_wmask = win0_mask;

  // Replace window bits with the base, keep the offset
  assign xlat_addr = (win0tb_q & win0_mask) | (UP_ADDR & ~win0_mask);

  // Control and link words keep their read-only bits
  assign slot_wr = be_merge(slot_q, CFG_CMD.wdata, CFG_CMD.be, `WM_SLOT);
  assign link0_wr = be_merge(link0_q, CFG_CMD.wdata, CFG_CMD.be, `WM_LINK0);
  assign link1_wr = be_merge(link1_q, CFG_CMD.wdata, CFG_CMD.be, `WM_LINK1);
  assign link2_wr = be_merge(link2_q, CFG_CMD.wdata, CFG_CMD.be, `WM_LINK2);

  // Data word and translated base under byte enables
  assign pd_word_wr = be_merge(pd_word_q, CFG_CMD.wdata, CFG_CMD.be, `WM_PDWORD);
  assign win0tb_wr = be_merge(win0tb_q, CFG_CMD.wdata, CFG_CMD.be, win0_wmask);

  // An address written with the start drives that very cycle
  assign engine_addr = wr_en && hit_pdcap && CFG_CMD.be[2] ?
                       CFG_CMD.wdata[`PD_ADDR_HI:`PD_ADDR_LO] : pd_addr_q;

  // Read data selection, unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      hit_slot: rd_mux = slot_q;
      hit_link0: rd_mux = link0_q;
      hit_link1: rd_mux = link1_q;
      hit_link2: rd_mux = link2_q;
      hit_pdcap: rd_mux = pd_cap_word;
      hit_pdword: rd_mux = pd_word_q;
      hit_win0tb: rd_mux = win0tb_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Access acknowledge and read data, one cycle after the request
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CFG_ACK <= 1'b0;
      CFG_RDATA <= 32'h0000_0000;
    end else begin
      CFG_ACK <= CFG_REQ;
      // Reads return the selected word, writes return zero
      CFG_RDATA <= CFG_REQ && !CFG_CMD.wr ? rd_mux : 32'h0000_0000;
    end
  end

  // Slot control writes and status capture
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      slot_q <= `RST_SLOT;
    end else begin
      // Status half mirrors the hot-plug flags, read-only
      slot_q[31:16] <= {9'h000, SLOT_EVT};
      // Control half takes the write, reserved bits stay zero
      if (wr_en && hit_slot) begin
        slot_q[15:0] <= slot_wr[15:0];
      end
    end
  end

  // Link tuning words
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      link0_q <= `RST_LINK0;
      link1_q <= `RST_LINK1;
      link2_q <= `RST_LINK2;
    end else begin
      // Each word is written at its own offset
      if (wr_en && hit_link0) begin
        link0_q <= link0_wr;
      end
      if (wr_en && hit_link1) begin
        link1_q <= link1_wr;
      end
      if (wr_en && hit_link2) begin
        link2_q <= link2_wr;
      end
    end
  end

  // Product data address, flag and busy tracking
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pd_addr_q <= 6'h00;
      pd_flag_q <= 1'b0;
      pd_busy_q <= 1'b0;
    end else begin
      // Address byte is locked while a cycle runs
      if (wr_en && hit_pdcap && CFG_CMD.be[2] && !pd_busy_q) begin
        pd_addr_q <= CFG_CMD.wdata[`PD_ADDR_HI:`PD_ADDR_LO];
      end
      // Start latches the operation, completion flips it
      if (pd_start) begin
        pd_flag_q <= pd_op; // Holds written value while running
        pd_busy_q <= 1'b1;
      end else if (pd_done) begin
        pd_flag_q <= ~pd_flag_q; // Read sets, write clears
        pd_busy_q <= 1'b0;
      end
    end
  end

  // Product data word: software writes, read completion loads
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pd_word_q <= `RST_PDWORD;
    end else begin
      // A finished read wins over a software write
      if (pd_done && !pd_flag_q) begin
        pd_word_q <= pd_rdata;
      end else if (wr_en && hit_pdword) begin
        pd_word_q <= pd_word_wr;
      end
    end
  end

  // Translated base word, low bits fixed at zero
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      win0tb_q <= `RST_WIN0TB;
    end else if (wr_en && hit_win0tb) begin
      win0tb_q <= win0tb_wr;
    end
  end

  // Registered upstream address translation
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      UP_XLAT_VALID <= 1'b0;
      UP_XLAT_ADDR <= 32'h0000_0000;
    end else begin
      UP_XLAT_VALID <= UP_VALID;
      // Address holds between requests
      if (UP_VALID) begin
        UP_XLAT_ADDR <= xlat_addr;
      end
    end
  end

  // Control outputs are the stored fields themselves
  assign SLOT_CTL = slot_q[10:0];

  // Link word 0 knobs
  assign LINK_CFG.hot_reset_en = link0_q[0];
  assign LINK_CFG.loopback_en = link0_q[1];
  assign LINK_CFG.crosslink_en = link0_q[2];
  assign LINK_CFG.force_config = link0_q[3];
  assign LINK_CFG.debug_sel = link0_q[4];
  assign LINK_CFG.lane_retries = link0_q[7:5];
  assign LINK_CFG.ts1_count = link0_q[12:8];
  assign LINK_CFG.l1_entry_timer = link0_q[31:16];

  // Link word 1 knobs
  assign LINK_CFG.l0s_life_timer = link1_q[9:0];
  assign LINK_CFG.l1_life_timer = link1_q[31:16];

  // Each FTS set is one comma symbol then three K28.1 symbols
  assign LINK_CFG.cdr_fts_count = link2_q[7:0];
  assign LINK_CFG.l0s_exit_lat = link2_q[14:8];
  assign LINK_CFG.l1_exit_lat = link2_q[22:16];

  // EEPROM cycle engine
  product_data_engine u_engine (
    .clk(CLK),
    .reset_n(RESET_N),
    .start(pd_start),
    .op_write(pd_op),
    .dword_addr(engine_addr),
    .wdata(pd_word_q),
    .done(pd_done),
    .rdata(pd_rdata),
    .ee_req(EE_REQ),
    .ee_we(EE_WE),
    .ee_addr(EE_ADDR),
    .ee_wdata(EE_WDATA),
    .ee_done(EE_DONE),
    .ee_rdata(EE_RDATA)
  );

endmodule

`default_nettype wire

// [bridge_slot_link_vpd_config_tb.sv]
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench of the config bank
module bridge_slot_link_vpd_config_tb
  import bridge_cfg_pkg::*;
;
  logic CLK = 1'b0, RESET_N = 1'b0, CFG_REQ = 1'b0, UP_VALID = 1'b0;
  logic CFG_ACK, UP_XLAT_VALID, EE_REQ, EE_WE, EE_DONE;
  cfg_req_t CFG_CMD = '0;
  logic [31:0] CFG_RDATA, UP_XLAT_ADDR, EE_WDATA, EE_RDATA, rd, d, x;
  logic [31:0] UP_ADDR = '0;
  logic [30:12] WIN0_SIZE = '0;
  slot_evt_t SLOT_EVT = '0;
  slot_ctl_t SLOT_CTL;
  link_tuning_t LINK_CFG;
  logic [8:0] EE_ADDR;
  logic [31:0] regs [8]; // Expected words, c8h upward
  int miscompares = 0, compares = 0, i, n;
  int ix [7] = '{0, 1, 2, 3, 5, 6, 7}; // Offsets open to random writes

  always #5 CLK = ~CLK;

  bridge_slot_link_vpd_config uut (.CLK(CLK), .RESET_N(RESET_N), .CFG_REQ(CFG_REQ),
    .CFG_CMD(CFG_CMD), .CFG_ACK(CFG_ACK), .CFG_RDATA(CFG_RDATA), .SLOT_EVT(SLOT_EVT),
    .SLOT_CTL(SLOT_CTL), .LINK_CFG(LINK_CFG), .WIN0_SIZE(WIN0_SIZE), .UP_VALID(UP_VALID),
    .UP_ADDR(UP_ADDR), .UP_XLAT_VALID(UP_XLAT_VALID), .UP_XLAT_ADDR(UP_XLAT_ADDR),
    .EE_REQ(EE_REQ), .EE_WE(EE_WE), .EE_ADDR(EE_ADDR), .EE_WDATA(EE_WDATA),
    .EE_DONE(EE_DONE), .EE_RDATA(EE_RDATA));
  ee_ctrl_model ee (.clk(CLK), .ee_req(EE_REQ), .ee_we(EE_WE), .ee_addr(EE_ADDR),
    .ee_wdata(EE_WDATA), .ee_done(EE_DONE), .ee_rdata(EE_RDATA));

  // Compare one value
  task chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Verdict and stop
  task end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Step just past a rising edge
  task tick;
    @(posedge CLK);
    #1;
  endtask
  // One config access, data in rd
  task cfg(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    tick();
    CFG_REQ = 1'b1;
    CFG_CMD = '{w, a, be, wd};
    tick();
    CFG_REQ = 1'b0;
    rd = CFG_RDATA;
    chk(CFG_ACK, 1'b1, "ack");
  endtask
  // Writable bits per word
  function automatic logic [31:0] wmask(int k);
    case (k)
      0: return 32'h0000_07ff;
      1: return 32'hffff_1fff;
      2: return 32'hffff_03ff;
      3: return 32'h007f_7fff;
      5: return 32'hffff_ffff;
      6: return {1'b1, WIN0_SIZE, 12'h0};
      default: return 32'h0;
    endcase
  endfunction
  // Word expected on a read
  function automatic logic [31:0] expv(int k);
    if (k == 0) return {9'h0, SLOT_EVT, regs[0][15:0]};
    return regs[k];
  endfunction
  // Link knobs expected from the words
  function automatic link_tuning_t lk();
    return {regs[1][0], regs[1][1], regs[1][2], regs[1][3], regs[1][4], regs[1][7:5],
      regs[1][12:8], regs[1][31:16], regs[2][9:0], regs[2][31:16], regs[3][7:0],
      regs[3][14:8], regs[3][22:16]};
  endfunction
  // Write access plus model update under byte enables
  task automatic wr(int k, logic [3:0] be, logic [31:0] wd);
    logic [31:0] m;
    m = wmask(k) & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    cfg(1'b1, 8'hc8 + 8'(4 * k), be, wd);
    regs[k] = (regs[k] & ~m) | (wd & m);
  endtask
  // Reset, then every word and the link knobs at their reset values
  task rst;
    RESET_N = 1'b0;
    repeat (10) tick();
    RESET_N = 1'b1;
    regs = '{32'h0, 32'h0400_1060, 32'h0400_0217, 32'h0019_0254, 32'h0000_f003, 0, 0, 0};
    for (int k = 0; k < 8; k++) begin
      cfg(1'b0, 8'hc8 + 8'(4 * k), 4'hf, 32'h0);
      chk(rd, expv(k), "reset word");
    end
    chk(LINK_CFG, lk(), "reset knobs");
  endtask
  // EEPROM cycle; a second start while busy is refused
  task automatic vpd(logic op, logic [5:0] a);
    cfg(1'b1, 8'hd8, 4'hc, {op, 7'h0, a, 18'h0});
    cfg(1'b1, 8'hd8, 4'hc, {!op, 7'h0, ~a, 18'h0});
    n = 0;
    do begin
      cfg(1'b0, 8'hd8, 4'hf, 32'h0);
      n++;
    end while (n < 60 && rd[31] !== !op);
    chk(rd, {!op, 7'h0, a, 2'b00, 16'hf003}, "flag");
    if (rd[31] !== !op) end_of_test();
  endtask

  // Main sequence
  initial begin
    rd = $urandom(32'h47fcd7af);
    rst();
    foreach (ix[j]) begin
      wr(ix[j], 4'hf, 32'hffff_ffff);
      cfg(1'b0, 8'hc8 + 8'(4 * ix[j]), 4'hf, 32'h0);
      chk(rd, expv(ix[j]), "all ones");
    end
    repeat (80) begin
      i = ix[$urandom_range(6)];
      SLOT_EVT = slot_evt_t'($urandom);
      WIN0_SIZE = 19'($urandom);
      tick();
      if ($urandom_range(1)) wr(i, 4'($urandom), $urandom);
      else cfg(1'b0, 8'hc8 + 8'(4 * i), 4'($urandom), 32'h0);
      if (!CFG_CMD.wr) chk(rd, expv(i), "read back");
      chk(LINK_CFG, lk(), "knobs");
      chk(SLOT_CTL, regs[0][10:0], "slot control");
    end
    repeat (60) begin
      WIN0_SIZE = 19'($urandom);
      UP_VALID = 1'($urandom);
      UP_ADDR = $urandom;
      x = (regs[6] & {1'b1, WIN0_SIZE, 12'h0}) | (UP_ADDR & ~{1'b1, WIN0_SIZE, 12'h0});
      i = UP_VALID;
      tick();
      chk(UP_XLAT_VALID, i[0], "xlat valid");
      if (i[0]) chk(UP_XLAT_ADDR, x, "xlat addr");
    end
    foreach (ix[j]) begin
      i = (j == 0) ? 63 : $urandom_range(63);
      d = $urandom;
      wr(5, 4'hf, d);
      vpd(1'b1, 6'(i));
      chk(ee.mem[i + 16], d, "eeprom word");
      wr(5, 4'hf, ~d);
      vpd(1'b0, 6'(i));
      cfg(1'b0, 8'hdc, 4'hf, 32'h0);
      chk(rd, d, "product word");
    end
    rst();
    end_of_test();
  end
endmodule

`default_nettype wire

// [cfg_bank_chk.sv]
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the config bank
module cfg_bank_chk
  import bridge_cfg_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Config access
  input wire logic CFG_REQ,
  input wire cfg_req_t CFG_CMD,
  input wire logic CFG_ACK,
  input wire logic [31:0] CFG_RDATA,
  // Upstream translation
  input wire logic UP_VALID,
  input wire logic [31:0] UP_ADDR,
  input wire logic UP_XLAT_VALID,
  input wire logic [31:0] UP_XLAT_ADDR,
  // EEPROM side
  input wire logic EE_REQ,
  input wire logic EE_WE,
  input wire logic [8:0] EE_ADDR,
  input wire logic EE_DONE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Read request of any offset
  wire rd = CFG_REQ && !CFG_CMD.wr;
  // Write that may start an EEPROM cycle
  wire go = CFG_REQ && CFG_CMD.wr && CFG_CMD.addr == 8'hd8 && CFG_CMD.be[3];
  ack_next_a: assert property (CFG_REQ |=> CFG_ACK)
    else $error("ack missing");
  ack_only_a: assert property (!CFG_REQ |=> !CFG_ACK)
    else $error("stray ack");
  wr_zero_a: assert property (CFG_REQ && CFG_CMD.wr |=> CFG_RDATA == 32'h0)
    else $error("write returned data");
  cap_hdr_a: assert property (rd && CFG_CMD.addr == 8'hd8 |=>
    CFG_RDATA[15:0] == 16'hf003) else $error("capability header wrong");
  slot_rsvd_a: assert property (rd && CFG_CMD.addr == 8'hc8 |=>
    CFG_RDATA[31:23] == 9'h0 && CFG_RDATA[15:11] == 5'h0) else $error("slot reserved set");
  ee_start_a: assert property (go && CFG_CMD.be[2] && !EE_REQ &&
    !$past(EE_REQ) && !$past(EE_REQ, 2) |=> EE_REQ && EE_WE == $past(CFG_CMD.wdata[31])
    && EE_ADDR == {1'b0, $past(CFG_CMD.wdata[23:18]), 2'b00} + 9'h040)
    else $error("eeprom start wrong");
  ee_idle_a: assert property (!EE_REQ && !go |=> !EE_REQ)
    else $error("eeprom request without start");
  ee_hold_a: assert property (EE_REQ && !EE_DONE |=>
    EE_REQ && $stable(EE_ADDR) && $stable(EE_WE)) else $error("eeprom request moved");
  ee_drop_a: assert property (EE_REQ && EE_DONE |=> !EE_REQ)
    else $error("eeprom request kept");
  xlat_vld_a: assert property (UP_VALID |=> UP_XLAT_VALID)
    else $error("translation valid missing");
  xlat_low_a: assert property (UP_VALID |=>
    UP_XLAT_ADDR[11:0] == $past(UP_ADDR[11:0])) else $error("offset bits changed");
  // Main scenarios
  cover property (go ##1 EE_REQ && EE_WE);
  cover property (go ##1 EE_REQ && !EE_WE);
  cover property (EE_REQ && EE_DONE);
  cover property (UP_VALID ##1 UP_XLAT_VALID);
endmodule

bind bridge_slot_link_vpd_config cfg_bank_chk chk (.CLK(CLK), .RESET_N(RESET_N),
  .CFG_REQ(CFG_REQ), .CFG_CMD(CFG_CMD), .CFG_ACK(CFG_ACK), .CFG_RDATA(CFG_RDATA),
  .UP_VALID(UP_VALID), .UP_ADDR(UP_ADDR), .UP_XLAT_VALID(UP_XLAT_VALID),
  .UP_XLAT_ADDR(UP_XLAT_ADDR), .EE_REQ(EE_REQ), .EE_WE(EE_WE), .EE_ADDR(EE_ADDR),
  .EE_DONE(EE_DONE));

`default_nettype wire

// [ee_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none

// EEPROM controller stand-in, answers after a random wait
module ee_ctrl_model (
  // Clock
  input wire logic clk,
  // Request from the bridge
  input wire logic ee_req,
  input wire logic ee_we,
  input wire logic [8:0] ee_addr,
  input wire logic [31:0] ee_wdata,
  // Completion
  output logic ee_done,
  output logic [31:0] ee_rdata
);
  logic [31:0] mem [128]; // Word store, one word per four bytes
  int wait_n = 0; // Cycles left until done
  // Known contents to read back
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = {4{8'(i)}} ^ 32'h5a3c_0f96;
    ee_done = 1'b0;
    ee_rdata = 32'h0;
  end
  // One request at a time, answered in 2 to 7 cycles
  always @(posedge clk) begin
    #1;
    ee_rdata = ~ee_rdata; // No stale data outside done
    if (ee_done) begin
      ee_done = 1'b0;
    end else if (ee_req) begin
      if (wait_n == 0) wait_n = 2 + $urandom_range(5);
      wait_n--;
      if (wait_n == 0) begin
        if (ee_we) mem[ee_addr[8:2]] = ee_wdata;
        else ee_rdata = mem[ee_addr[8:2]];
        ee_done = 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// [product_data_engine.sv]
`timescale 1ns/1ps
`default_nettype none

`include "bridge_cfg_defines.svh"

// Runs one EEPROM read or write cycle for the product data capability
module product_data_engine
  import bridge_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Start from the register bank
  input wire logic start,
  input wire logic op_write,
  input wire logic [5:0] dword_addr,
  input wire logic [31:0] wdata,
  // Completion to the register bank
  output logic done,
  output logic [31:0] rdata,
  // EEPROM controller side
  output logic ee_req,
  output logic ee_we,
  output logic [8:0] ee_addr,
  output logic [31:0] ee_wdata,
  input wire logic ee_done,
  input wire logic [31:0] ee_rdata
);

  ee_state_t state_q; // Cycle state
  ee_state_t state_d; // Next cycle state
  wire [8:0] byte_addr; // EEPROM byte address of the dword

  // Product data sits above the EEPROM's own setup area
  assign byte_addr = {1'b0, dword_addr, 2'b00} + `PD_EE_OFFSET;

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      EE_IDLE: begin
        if (start) begin
          state_d = EE_ISSUE;
        end
      end
      EE_ISSUE: state_d = EE_WAIT;
      EE_WAIT: begin
        if (ee_done) begin
          state_d = EE_IDLE;
        end
      end
      default: state_d = EE_IDLE;
    endcase
  end

  // State register and EEPROM request, held until done
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= EE_IDLE;
      ee_req <= 1'b0;
      ee_we <= 1'b0;
      ee_addr <= 9'h000;
      ee_wdata <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      if (state_q == EE_IDLE && start) begin
        ee_req <= 1'b1;
        ee_we <= op_write;
        ee_addr <= byte_addr;
        ee_wdata <= wdata;
      end else if (state_q == EE_WAIT && ee_done) begin
        ee_req <= 1'b0;
      end
    end
  end

  // Completion pulse and captured read data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      done <= (state_q == EE_WAIT) && ee_done;
      if (state_q == EE_WAIT && ee_done && !ee_we) begin
        rdata <= ee_rdata; // Lowest byte is the addressed one
      end
    end
  end

endmodule

`default_nettype wire
